// ---- inc/npport_pkg.sv ----
// Constants and carrier types for the processor register port.
package npport_pkg;

  // Register select offsets.
  localparam logic [6:0] OFF_CMD_ONE    = 7'h00;
  localparam logic [6:0] OFF_CMD_TWO    = 7'h01;
  localparam logic [6:0] OFF_ST_ONE_U   = 7'h00;
  localparam logic [6:0] OFF_ST_ONE_L   = 7'h01;
  localparam logic [6:0] OFF_ST_TWO_U   = 7'h02;
  localparam logic [6:0] OFF_ST_TWO_L   = 7'h03;
  localparam logic [6:0] OFF_MSK_ONE_U  = 7'h04;
  localparam logic [6:0] OFF_MSK_ONE_L  = 7'h05;
  localparam logic [6:0] OFF_MSK_TWO_U  = 7'h06;
  localparam logic [6:0] OFF_MSK_TWO_L  = 7'h07;
  localparam logic [6:0] OFF_SHORT_IND  = 7'h08;
  localparam logic [6:0] OFF_LONG_IND_H = 7'h09;
  localparam logic [6:0] OFF_LONG_IND_M = 7'h0A;
  localparam logic [6:0] OFF_LONG_IND_L = 7'h0B;
  localparam logic [6:0] OFF_SHORT_GRP  = 7'h0C;
  localparam logic [6:0] OFF_LONG_GRP_H = 7'h0D;
  localparam logic [6:0] OFF_LONG_GRP_M = 7'h0E;
  localparam logic [6:0] OFF_LONG_GRP_L = 7'h0F;
  localparam logic [6:0] OFF_MODE_ONE   = 7'h10;
  localparam logic [6:0] OFF_SM_STATUS  = 7'h11;
  localparam logic [6:0] OFF_MAC_INFO_U = 7'h12;
  localparam logic [6:0] OFF_MAC_INFO_L = 7'h13;

  // Command codes carried in the low nibble of a command_one write.
  localparam logic [3:0] CMD1_ENTER_INIT = 4'h1;
  localparam logic [3:0] CMD1_LEAVE_INIT = 4'h2;

  // Values after reset.
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [31:0] RST_MASK      = 32'h00000000;
  localparam logic [47:0] RST_LONG_ADDR = 48'h000000000000;
  localparam logic        RST_INIT_MODE = 1'b1;

  // Pin-side request as seen after sampling.
  typedef struct packed {
    logic        sel;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] data;
  } pin_req_t;

  // Software-written configuration handed to the controller core.
  typedef struct packed {
    logic [31:0] int_mask_one;
    logic [31:0] int_mask_two;
    logic [15:0] short_individual_address;
    logic [47:0] long_individual_address;
    logic [15:0] short_group_address;
    logic [47:0] long_group_address;
    logic [15:0] mode_one;
  } cfg_t;

  typedef enum logic [1:0] {PS_IDLE, PS_READ, PS_WRITE} port_st_t;

endpackage

// ---- core/npport.sv ----
// Processor register port: pin sampling, register file and command decode.
//
// Contract
// R1: Strap high: port transfers run synchronous to the core clock.
// R2: Strap low: port transfers are asynchronous and resynchronised internally.
// R3: The 7-bit select bus alone picks the register accessed.
// R4: Direction 1 drives register onto data bus; 0 loads it from bus.
// R5: Address registers accept writes only while in initialization mode.
// R6: Writes to 00H/01H execute a command instead of storing data.
// R7: Reads 00H-03H return status one upper/lower, status two upper/lower.
// R8: Interrupt masks one and two read/write as halves at 04H-07H.
// R9: Individual address: short at 08H, long over 09H, 0AH, 0BH.
// R10: Group address: short at 0CH, long over 0DH, 0EH, 0FH.
// R11: Mode register one is read/write at 10H.
// R12: State machine status is read-only at 11H.
// R13: MAC info read-only, upper half at 12H, lower at 13H.
// R14: Data bus is driven only during reads, released during writes.
`timescale 1ns/10ps
module npport (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  input  wire logic                 PORT_TIMING_STRAP,
  input  wire logic                 SELECT_N,
  input  wire logic                 READ_NOT_WRITE,
  input  wire logic [6:0]           REGISTER_SELECT_BUS,
  input  wire logic [15:0]          PROCESSOR_DATA_BUS_IN,
  output logic      [15:0]          PROCESSOR_DATA_BUS_OUT,
  output logic                      PROCESSOR_DATA_BUS_OE_N,
  input  wire logic [31:0]          STATUS_ONE,
  input  wire logic [31:0]          STATUS_TWO,
  input  wire logic [15:0]          STATE_MACHINE_STATUS,
  input  wire logic [31:0]          MAC_INFO_VALUE,
  output npport_pkg::cfg_t          CFG,
  output logic                      INIT_MODE,
  output logic                      CMD_ONE_STB,
  output logic                      CMD_TWO_STB,
  output logic      [15:0]          CMD_CODE,
  output logic                      REFUSED_STB
);
  import npport_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling.

  pin_req_t pin_now;
  pin_req_t sync_q_r;
  pin_req_t sync_qd_r;
  pin_req_t meta_r;
  pin_req_t res_r;
  pin_req_t res_d_r;
  logic     strap_meta_r;
  logic     strap_res_r;

  assign pin_now = '{sel:  ~SELECT_N,
                     rd:   READ_NOT_WRITE,
                     addr: REGISTER_SELECT_BUS,
                     data: PROCESSOR_DATA_BUS_IN};

  // The async chain is two stages deep; only res_r and later stages feed logic.
  // The sync path takes one register stage since the processor shares our clock.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sync_q_r     <= '0;
      sync_qd_r    <= '0;
      meta_r       <= '0;
      res_r        <= '0;
      res_d_r      <= '0;
    end else begin
      sync_q_r     <= pin_now;
      sync_qd_r    <= sync_q_r;
      meta_r       <= pin_now;
      res_r        <= meta_r;
      res_d_r      <= res_r;
    end
  end

  // The strap flops run through reset, so the level has settled by the capture edge.
  always_ff @(posedge CORE_CLK) begin
    strap_meta_r <= PORT_TIMING_STRAP;
    strap_res_r  <= strap_meta_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture: the timing mode is frozen once after reset release.

  logic sync_mode_r;
  logic sync_mode_nxt;
  logic strap_ld_r;
  logic strap_ld_nxt;

  // The strap is a static level, so catching it once is enough.
  always_comb begin
    sync_mode_nxt = sync_mode_r;
    strap_ld_nxt  = strap_ld_r;
    if (!strap_ld_r && !RST) begin
      sync_mode_nxt = strap_res_r;
      strap_ld_nxt  = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sync_mode_r <= 1'b0;
      strap_ld_r  <= 1'b0;
    end else begin
      sync_mode_r <= sync_mode_nxt;
      strap_ld_r  <= strap_ld_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request selection by timing mode.

  pin_req_t req;
  logic     take;

  always_comb begin
    // R1: sync timing
    if (sync_mode_r) begin
      req  = sync_q_r;
      take = sync_q_r.sel && !sync_qd_r.sel && strap_ld_r;
    // R2: async timing
    end else begin
      req  = res_r;
      take = res_r.sel && !res_d_r.sel && strap_ld_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file, command decode and data bus control.

  port_st_t    st_r,      st_nxt;
  cfg_t        cfg_r,     cfg_nxt;
  logic        init_r,    init_nxt;
  logic [15:0] dout_r,    dout_nxt;
  logic        oe_n_r,    oe_n_nxt;
  logic        c1_r,      c1_nxt;
  logic        c2_r,      c2_nxt;
  logic [15:0] code_r,    code_nxt;
  logic        ref_r,     ref_nxt;
  logic [15:0] rd_word;
  logic        addr_reg;

  // R3: address decode
  always_comb begin
    case (req.addr)
      // R7: status halves
      OFF_ST_ONE_U:   rd_word = STATUS_ONE[31:16];
      OFF_ST_ONE_L:   rd_word = STATUS_ONE[15:0];
      OFF_ST_TWO_U:   rd_word = STATUS_TWO[31:16];
      OFF_ST_TWO_L:   rd_word = STATUS_TWO[15:0];
      OFF_MSK_ONE_U:  rd_word = cfg_r.int_mask_one[31:16];
      OFF_MSK_ONE_L:  rd_word = cfg_r.int_mask_one[15:0];
      OFF_MSK_TWO_U:  rd_word = cfg_r.int_mask_two[31:16];
      OFF_MSK_TWO_L:  rd_word = cfg_r.int_mask_two[15:0];
      OFF_SHORT_IND:  rd_word = cfg_r.short_individual_address;
      OFF_LONG_IND_H: rd_word = cfg_r.long_individual_address[47:32];
      OFF_LONG_IND_M: rd_word = cfg_r.long_individual_address[31:16];
      OFF_LONG_IND_L: rd_word = cfg_r.long_individual_address[15:0];
      OFF_SHORT_GRP:  rd_word = cfg_r.short_group_address;
      OFF_LONG_GRP_H: rd_word = cfg_r.long_group_address[47:32];
      OFF_LONG_GRP_M: rd_word = cfg_r.long_group_address[31:16];
      OFF_LONG_GRP_L: rd_word = cfg_r.long_group_address[15:0];
      OFF_MODE_ONE:   rd_word = cfg_r.mode_one;
      // R12: state machine status
      OFF_SM_STATUS:  rd_word = STATE_MACHINE_STATUS;
      // R13: MAC info halves
      OFF_MAC_INFO_U: rd_word = MAC_INFO_VALUE[31:16];
      OFF_MAC_INFO_L: rd_word = MAC_INFO_VALUE[15:0];
      default:        rd_word = RST_WORD;
    endcase
    addr_reg = (req.addr >= OFF_SHORT_IND) && (req.addr <= OFF_LONG_GRP_L);
  end

  // One access per select assertion; the bus is held until select drops.
  always_comb begin
    st_nxt   = st_r;
    cfg_nxt  = cfg_r;
    init_nxt = init_r;
    dout_nxt = dout_r;
    oe_n_nxt = oe_n_r;
    c1_nxt   = 1'b0;
    c2_nxt   = 1'b0;
    code_nxt = code_r;
    ref_nxt  = 1'b0;
    case (st_r)
      PS_IDLE: begin
        if (take && req.rd) begin
          // R4: read drives bus
          dout_nxt = rd_word;
          oe_n_nxt = 1'b0;
          st_nxt   = PS_READ;
        end else if (take) begin
          st_nxt = PS_WRITE;
          // R5: init-only registers
          if (addr_reg && !init_r) begin
            ref_nxt = 1'b1;
          end else begin
            case (req.addr)
              // R6: command execution
              OFF_CMD_ONE: begin
                c1_nxt   = 1'b1;
                code_nxt = req.data;
                if (req.data[3:0] == CMD1_ENTER_INIT) begin
                  init_nxt = 1'b1;
                end else if (req.data[3:0] == CMD1_LEAVE_INIT) begin
                  init_nxt = 1'b0;
                end
              end
              OFF_CMD_TWO: begin
                c2_nxt   = 1'b1;
                code_nxt = req.data;
              end
              // R8: mask halves
              OFF_MSK_ONE_U:  cfg_nxt.int_mask_one[31:16] = req.data;
              OFF_MSK_ONE_L:  cfg_nxt.int_mask_one[15:0] = req.data;
              OFF_MSK_TWO_U:  cfg_nxt.int_mask_two[31:16] = req.data;
              OFF_MSK_TWO_L:  cfg_nxt.int_mask_two[15:0] = req.data;
              // R9: individual address
              OFF_SHORT_IND:  cfg_nxt.short_individual_address = req.data;
              OFF_LONG_IND_H: cfg_nxt.long_individual_address[47:32] = req.data;
              OFF_LONG_IND_M: cfg_nxt.long_individual_address[31:16] = req.data;
              OFF_LONG_IND_L: cfg_nxt.long_individual_address[15:0] = req.data;
              // R10: group address
              OFF_SHORT_GRP:  cfg_nxt.short_group_address = req.data;
              OFF_LONG_GRP_H: cfg_nxt.long_group_address[47:32] = req.data;
              OFF_LONG_GRP_M: cfg_nxt.long_group_address[31:16] = req.data;
              OFF_LONG_GRP_L: cfg_nxt.long_group_address[15:0] = req.data;
              // R11: mode register
              OFF_MODE_ONE:   cfg_nxt.mode_one = req.data;
              default:        cfg_nxt = cfg_r;
            endcase
          end
        end
      end
      PS_READ: begin
        // R14: release on select drop
        if (!req.sel) begin
          oe_n_nxt = 1'b1;
          st_nxt   = PS_IDLE;
        end
      end
      PS_WRITE: begin
        if (!req.sel) begin
          st_nxt = PS_IDLE;
        end
      end
      default: begin
        oe_n_nxt = 1'b1;
        st_nxt   = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_r   <= PS_IDLE;
      cfg_r  <= '{int_mask_one: RST_MASK, int_mask_two: RST_MASK,
                  short_individual_address: RST_WORD,
                  long_individual_address: RST_LONG_ADDR,
                  short_group_address: RST_WORD,
                  long_group_address: RST_LONG_ADDR, mode_one: RST_WORD};
      init_r <= RST_INIT_MODE;
      dout_r <= RST_WORD;
      oe_n_r <= 1'b1;
      c1_r   <= 1'b0;
      c2_r   <= 1'b0;
      code_r <= RST_WORD;
      ref_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cfg_r  <= cfg_nxt;
      init_r <= init_nxt;
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      c1_r   <= c1_nxt;
      c2_r   <= c2_nxt;
      code_r <= code_nxt;
      ref_r  <= ref_nxt;
    end
  end

  assign PROCESSOR_DATA_BUS_OUT  = dout_r;
  assign PROCESSOR_DATA_BUS_OE_N = oe_n_r;
  assign CFG                     = cfg_r;
  assign INIT_MODE               = init_r;
  assign CMD_ONE_STB             = c1_r;
  assign CMD_TWO_STB             = c2_r;
  assign CMD_CODE                = code_r;
  assign REFUSED_STB             = ref_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic rd_take;
  logic wr_take;
  assign rd_take = take && req.rd && st_r == PS_IDLE;
  assign wr_take = take && !req.rd && st_r == PS_IDLE;

  sequence s_sync_fall;
    sync_mode_r && strap_ld_r && st_r == PS_IDLE && !sync_q_r.sel && !SELECT_N;
  endsequence
  sequence s_async_fall;
    !sync_mode_r && strap_ld_r && st_r == PS_IDLE && $past(SELECT_N) && !res_r.sel
      && !SELECT_N;
  endsequence

  a_sync_take_time: assert property (s_sync_fall |=> take) // R1
    else $error("sync-mode select not taken one cycle later");
  a_async_take_time: assert property (s_async_fall ##1 !SELECT_N |=> take) // R2
    else $error("async-mode select not taken after two stages");
  a_read_drives_bus: assert property (rd_take |=> !PROCESSOR_DATA_BUS_OE_N) // R4
    else $error("read did not drive data bus");
  a_write_keeps_off: assert property (wr_take |=> PROCESSOR_DATA_BUS_OE_N [*2]) // R14
    else $error("data bus driven during write");
  a_cmd_one_exec: assert property (wr_take && req.addr == OFF_CMD_ONE
    |=> CMD_ONE_STB && CMD_CODE == $past(req.data) && CFG == $past(cfg_r)) // R6
    else $error("command one write not executed");
  a_init_refuse: assert property (wr_take && addr_reg && !init_r
    |=> REFUSED_STB && $stable(CFG)) // R5
    else $error("address write outside init mode not refused");
  a_status_read: assert property (rd_take && req.addr == OFF_ST_TWO_L
    |=> PROCESSOR_DATA_BUS_OUT == $past(STATUS_TWO[15:0])) // R7
    else $error("status two lower read wrong");
  a_mask_load: assert property (wr_take && req.addr == OFF_MSK_ONE_U
    |=> CFG.int_mask_one[31:16] == $past(req.data)) // R8
    else $error("mask one upper not loaded");
  a_ind_addr_load: assert property (wr_take && init_r && req.addr == OFF_LONG_IND_M
    |=> CFG.long_individual_address[31:16] == $past(req.data)) // R9
    else $error("individual long address middle not loaded");
  a_grp_addr_load: assert property (wr_take && init_r && req.addr == OFF_LONG_GRP_H
    |=> CFG.long_group_address[47:32] == $past(req.data)) // R10
    else $error("group long address high not loaded");
  a_mode_readback: assert property (rd_take && req.addr == OFF_MODE_ONE
    |=> PROCESSOR_DATA_BUS_OUT == $past(cfg_r.mode_one)) // R11
    else $error("mode one read back wrong");
  a_sm_read_only: assert property (wr_take && req.addr == OFF_SM_STATUS
    |=> $stable(CFG) && !REFUSED_STB) // R12
    else $error("write to state machine status changed state");
  a_mac_info_low: assert property (rd_take && req.addr == OFF_MAC_INFO_L
    |=> PROCESSOR_DATA_BUS_OUT == $past(MAC_INFO_VALUE[15:0])) // R13
    else $error("mac info lower read wrong");
  a_addr_only_sel: assert property (rd_take && req.addr == OFF_SHORT_GRP
    |=> PROCESSOR_DATA_BUS_OUT == $past(cfg_r.short_group_address)) // R3
    else $error("select bus picked wrong register");

endmodule

// ---- test/np_host_model.sv ----
// Node processor model that makes accesses on the register port.
`timescale 1ns/10ps
module np_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus,
  input  wire logic        oe_n,
  output logic             sel_n,
  output logic             rnw,
  output logic [6:0]       addr,
  output logic [15:0]      wr_data
);
  int   hold_extra;
  logic drv_wr;

  // Idle levels from time zero; hold_extra above 0 makes a slow processor.
  initial begin
    hold_extra = 0;
    drv_wr = 1'b0;
    sel_n = 1'b1;
    rnw = 1'b1;
    addr = 7'h00;
    wr_data = 16'h0000;
  end

  // No pull on the data lines, so a released bus shows a toggling pattern.
  always @(posedge clk) begin
    if (!drv_wr) wr_data <= ~wr_data;
  end

  // One access; bad flags the device driving the bus during a write or after the gap.
  task automatic access(input logic rd, input logic [6:0] a, input logic [15:0] d,
                        output logic [15:0] q, output int lat, output logic bad);
    int n;
    lat = 0;
    bad = 1'b0;
    q = 16'h0000;
    @(posedge clk);
    #1;
    sel_n = 1'b0;
    rnw = rd;
    addr = a;
    drv_wr = !rd;
    if (!rd) wr_data = d;
    for (n = 1; n <= 12; n++) begin
      @(posedge clk);
      #1;
      if (!rd && oe_n !== 1'b1) bad = 1'b1;
      if (rd && lat == 0 && oe_n === 1'b0) begin
        lat = n;
        q = bus;
      end
      if ((!rd || lat != 0) && n >= 5 + hold_extra) break;
    end
    sel_n = 1'b1;
    rnw = 1'b1;
    drv_wr = 1'b0;
    // The gap covers the slower asynchronous release path.
    repeat (5) @(posedge clk);
    #1;
    if (oe_n !== 1'b1) bad = 1'b1;
  endtask
endmodule

// ---- test/mac_host_register_port_bench.sv ----
// Self-checking bench for the processor register port.
`timescale 1ns/10ps
module mac_host_register_port_bench;
  import npport_pkg::*;
  logic        clk, rst, strap, sel_n, rnw, oe_n, init_mode, c1, c2, rf;
  logic [6:0]  addr;
  logic [15:0] hdata, dout, bus, smc, code;
  logic [31:0] st1, st2, mi;
  cfg_t        cfg;
  int          err_total = 0, checked = 0, cyc = 0, n_c1 = 0, n_c2 = 0, n_rf = 0;

  // The bus carries the device word while it drives, the host lines otherwise.
  assign bus = (oe_n === 1'b0) ? dout : hdata;

  npport DUT (
    .CORE_CLK(clk), .RST(rst), .PORT_TIMING_STRAP(strap), .SELECT_N(sel_n),
    .READ_NOT_WRITE(rnw), .REGISTER_SELECT_BUS(addr), .PROCESSOR_DATA_BUS_IN(bus),
    .PROCESSOR_DATA_BUS_OUT(dout), .PROCESSOR_DATA_BUS_OE_N(oe_n), .STATUS_ONE(st1),
    .STATUS_TWO(st2), .STATE_MACHINE_STATUS(smc), .MAC_INFO_VALUE(mi), .CFG(cfg),
    .INIT_MODE(init_mode), .CMD_ONE_STB(c1), .CMD_TWO_STB(c2), .CMD_CODE(code),
    .REFUSED_STB(rf)
  );

  np_host_model host (.clk(clk), .bus(bus), .oe_n(oe_n), .sel_n(sel_n), .rnw(rnw),
                      .addr(addr), .wr_data(hdata));

  // Clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Strobes are counted per cycle, so a stretched pulse shows as an extra count.
  always @(posedge clk) begin
    cyc++;
    if (c1 === 1'b1) n_c1++;
    if (c2 === 1'b1) n_c2++;
    if (rf === 1'b1) n_rf++;
    if (cyc >= 6000) begin
      err_total++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, report and count.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Distinct test word for each address.
  function automatic logic [15:0] pat(input int i);
    pat = 16'hA5C3 ^ (16'(i) * 16'h0111);
  endfunction

  // Write access; the device must leave the bus to the processor.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    int          lat;
    logic        bad;
    host.access(1'b0, a, d, q, lat, bad);
    check(bad, 1'b0);
  endtask

  // Read access; answer latency depends on the strap mode.
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    int          lat;
    logic        bad;
    host.access(1'b1, a, 16'h0000, q, lat, bad);
    check(q, exp);
    check(lat, strap ? 2 : 3);
    check(bad, 1'b0);
  endtask

  // Reset held for 8 cycles; the strap is settled while reset is high.
  task automatic do_reset(input logic s);
    @(posedge clk);
    #1;
    strap = s;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: synchronous mode first, then a second reset into async mode.
  initial begin
    int i;
    rst = 1'b1;
    strap = 1'b1;
    st1 = 32'h13579BDF;
    st2 = 32'h2468ACE0;
    mi = 32'hFEDC0123;
    smc = 16'h3C5A;
    do_reset(1'b1);
    check(init_mode, 1'b1);
    for (i = 4; i <= 16; i++) rd(7'(i), 16'h0000);
    for (i = 4; i <= 16; i++) wr(7'(i), pat(i));
    for (i = 4; i <= 16; i++) rd(7'(i), pat(i));
    check(cfg.int_mask_one, {pat(4), pat(5)});
    check(cfg.int_mask_two, {pat(6), pat(7)});
    check(cfg.short_individual_address, pat(8));
    check(cfg.long_individual_address, {pat(9), pat(10), pat(11)});
    check(cfg.short_group_address, pat(12));
    check(cfg.long_group_address, {pat(13), pat(14), pat(15)});
    check(cfg.mode_one, pat(16));
    // Read-only places keep their values when written.
    wr(OFF_ST_TWO_U, 16'hFFFF);
    wr(OFF_ST_TWO_L, 16'hFFFF);
    wr(OFF_SM_STATUS, 16'hFFFF);
    wr(OFF_MAC_INFO_L, 16'hFFFF);
    rd(OFF_ST_ONE_U, st1[31:16]);
    rd(OFF_ST_ONE_L, st1[15:0]);
    rd(OFF_ST_TWO_U, st2[31:16]);
    rd(OFF_ST_TWO_L, st2[15:0]);
    rd(OFF_SM_STATUS, smc);
    rd(OFF_MAC_INFO_U, mi[31:16]);
    rd(OFF_MAC_INFO_L, mi[15:0]);
    // Upper address bits must not alias onto a mapped register.
    wr(7'h48, 16'hBEEF);
    rd(OFF_SHORT_IND, pat(8));
    rd(7'h48, 16'h0000);
    check(cfg.mode_one, pat(16));
    // Leave initialization mode; address writes are then refused.
    wr(OFF_CMD_ONE, {12'h5A5, CMD1_LEAVE_INIT});
    check(n_c1, 1);
    check(code, {12'h5A5, CMD1_LEAVE_INIT});
    check(init_mode, 1'b0);
    for (i = 8; i <= 15; i++) wr(7'(i), ~pat(i));
    check(n_rf, 8);
    for (i = 8; i <= 15; i++) rd(7'(i), pat(i));
    wr(OFF_MODE_ONE, 16'h0F0F);
    rd(OFF_MODE_ONE, 16'h0F0F);
    wr(OFF_CMD_TWO, 16'h00C3);
    check(n_c2, 1);
    check(code, 16'h00C3);
    check(cfg.mode_one, 16'h0F0F);
    // back in initialization mode before touching addresses.
    wr(OFF_CMD_ONE, {12'h000, CMD1_ENTER_INIT});
    check(init_mode, 1'b1);
    check(n_c1, 2);
    wr(OFF_SHORT_IND, 16'h2222);
    rd(OFF_SHORT_IND, 16'h2222);
    check(n_rf, 8);
    // Second reset with the strap low and a slow processor.
    do_reset(1'b0);
    host.hold_extra = 3;
    rd(OFF_MODE_ONE, 16'h0000);
    wr(OFF_MSK_TWO_L, 16'h7E81);
    rd(OFF_MSK_TWO_L, 16'h7E81);
    check(cfg.int_mask_two, 32'h00007E81);
    rd(OFF_ST_TWO_L, st2[15:0]);
    give_verdict();
  end
endmodule
